// >>> tb_top.sv
// self-checking bench for the up/down timer
`timescale 1ns/10ps
`include "udt_map.svh"
module tb_top;
    typedef struct {logic [31:0] v; logic [31:0] tol; logic [1:0] irq;} udt_note_t;
    udt_note_t notes[$];
    udt_note_t cur;
    logic clk_in, resetn_in, hsel, hwrite, ext_pin, dir_pin, hready, hresp, irq;
    logic rd_dp = 1'h0;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, s;
    int bad_count, checked, n;
    initial begin
        clk_in = 1'h0;
        forever #25 clk_in = ~clk_in;
    end
    udt_timer i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .ext_count_pin_in(ext_pin), .direction_pin_in(dir_pin), .irq_out(irq));
    udt_pin_model i_pins (.clk_in(clk_in), .ext_count_pin_out(ext_pin),
        .direction_pin_out(dir_pin));
    task automatic tally_and_finish();
        $display("mismatches %0d, checks %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // irq note 2'h2 means the level is not looked at
    always @(posedge clk_in) begin
        if (rd_dp) begin
            cur = notes.pop_front();
            checked++;
            // unknown read data or a non-okay response must not slip through
            if ($isunknown(hrdata) || hresp !== 1'h0
                || (cur.tol == 0 ? hrdata !== cur.v : hrdata + cur.tol - cur.v > 2 * cur.tol)
                || (!cur.irq[1] && irq !== cur.irq[0])) begin
                $display("FAIL t=%0t got=%h exp=%h irq=%h", $time, hrdata, cur.v, irq);
                bad_count++;
            end
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
    end
    task automatic bus_req(input logic [7:0] a, input logic w);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        @(posedge clk_in);
        while (hready !== 1'h1) @(posedge clk_in);
        htrans <= 2'h0;
        hsel <= 1'h0;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        bus_req(a, 1'h1);
        hwdata <= d;
        @(posedge clk_in);
        while (hready !== 1'h1) @(posedge clk_in);
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] t,
        input logic [1:0] q);
        bus_req(a, 1'h0);
        notes.push_back('{v, t, q});
        @(posedge clk_in);
        while (hready !== 1'h1) @(posedge clk_in);
    endtask
    task automatic run_case(input logic [31:0] c, input logic [31:0] m, input logic up,
        input logic [31:0] st, input int k, input logic [31:0] ec, input logic [31:0] es);
        bus_wr(`UDT_STATUS_ADDR, 32'h0000_0003);
        bus_wr(`UDT_MODE_ADDR, m);
        i_pins.set_dir(up);
        bus_wr(`UDT_COUNT_ADDR, st);
        bus_wr(`UDT_CTRL_ADDR, c);
        i_pins.pulses(k, 1'($urandom_range(1, 0)));
        bus_wr(`UDT_CTRL_ADDR, 32'h0000_0000);
        bus_rd(`UDT_COUNT_ADDR, ec, 32'h0000_0000, 2'h2);
        bus_rd(`UDT_STATUS_ADDR, es, 32'h0000_0000, 2'h2);
        // second count read with the timer stopped gives the hold check a target
        bus_rd(`UDT_COUNT_ADDR, ec, 32'h0000_0000, 2'h2);
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {resetn_in, hsel, hwrite, htrans, haddr, hwdata} = 69'h0;
        bad_count = 0;
        checked = 0;
        void'($urandom(96));
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'h1;
        @(posedge clk_in);
        // the last address is unmapped and must read zero
        for (int a = 0; a <= 24; a += 4) bus_rd(a[7:0], 32'h0000_0000, 32'h0000_0000, 2'h0);
        bus_wr(`UDT_CTRL_ADDR, 32'h0000_0004);
        repeat (240) @(posedge clk_in);
        bus_wr(`UDT_CTRL_ADDR, 32'h0000_0000);
        bus_rd(`UDT_COUNT_ADDR, 32'h0000_0014, 32'h0000_0001, 2'h2);
        bus_wr(`UDT_RELOAD_ADDR, 32'h0000_1234);
        bus_rd(`UDT_RELOAD_ADDR, 32'h0000_1234, 32'h0000_0000, 2'h2);
        // random control bits with run held off; unused bits must read zero
        s = $urandom() & 32'hFFFF_FFFB;
        bus_wr(`UDT_CTRL_ADDR, s);
        bus_rd(`UDT_CTRL_ADDR, s & 32'h0000_0033, 32'h0000_0000, 2'h2);
        bus_wr(`UDT_CTRL_ADDR, 32'h0000_0000);
        bus_wr(`UDT_MASK_ADDR, 32'h0000_0003);
        run_case(32'h0000_0002, 0, 1, 32'h0000_0050, 3, 32'h0000_0050, 0);
        run_case(32'h0000_0006, 0, 0, 32'h0000_00FE, 3, 32'h0000_0101, 0);
        run_case(32'h0000_0006, 0, 1, 32'h0000_FFFE, 2, 32'h0000_1234, 1);
        run_case(32'h0000_0007, 0, 1, 32'h0000_FFFF, 1, 32'h0000_0000, 1);
        run_case(32'h0000_0016, 0, 1, 32'h0000_FFFF, 1, 32'h0000_1234, 0);
        run_case(32'h0000_0026, 0, 1, 32'h0000_FFFF, 1, 32'h0000_1234, 0);
        run_case(32'h0000_0006, 1, 1, 32'h0000_FFFF, 1, 32'h0000_1234, 3);
        bus_wr(`UDT_MASK_ADDR, 32'h0000_0002);
        bus_rd(`UDT_STATUS_ADDR, 32'h0000_0003, 32'h0000_0000, 2'h0);
        bus_wr(`UDT_MASK_ADDR, 32'h0000_0003);
        bus_rd(`UDT_STATUS_ADDR, 32'h0000_0003, 32'h0000_0000, 2'h1);
        bus_wr(`UDT_STATUS_ADDR, 32'h0000_0001);
        bus_rd(`UDT_STATUS_ADDR, 32'h0000_0002, 32'h0000_0000, 2'h0);
        run_case(32'h0000_0006, 1, 0, 32'h0000_1235, 2, 32'h0000_FFFF, 3);
        for (int i = 0; i < 4; i++) begin
            s = 32'h0000_2000 + $urandom_range(4095, 0);
            n = $urandom_range(8, 1);
            run_case(32'h0000_0006, 1, 0, s, n, s - n, 0);
        end
        tally_and_finish();
    end
endmodule

// >>> udt_map.svh
// register map, field positions, reset values and timing constants of the up/down timer
// What this block does
// R01 - count is sixteen bits: low byte plus high byte, high advances on low wrap
// R02 - counter/timer select: clear counts clock divided by 12, set counts pin edges
// R03 - low byte advances only while run control is set, otherwise count holds
// R04 - three modes: capture, auto-reload, baud rate; picked by clock selects and capture select
// R05 - auto-reload with down-count disabled is a plain up counter with reload
// R06 - auto-reload with down-count enabled takes direction from direction pin
// R07 - pin high counts up; passing FFFFh sets overflow flag and requests interrupt
// R08 - up overflow loads reload pair into count bytes
// R09 - pin low counts down; underflow when count equals reload pair
// R10 - down underflow sets overflow flag and loads FFFFh
// R11 - up/down mode toggles external flag on each wrap, never an interrupt
// R12 - software clears overflow flag; hardware never clears it
// R13 - counter operation advances on each falling edge of count pin
// R14 - count and direction pins are synchronised before edge detection
`ifndef UDT_MAP_SVH
`define UDT_MAP_SVH
`define UDT_CTRL_ADDR 8'h00
`define UDT_MODE_ADDR 8'h04
`define UDT_COUNT_ADDR 8'h08
`define UDT_RELOAD_ADDR 8'h0C
`define UDT_STATUS_ADDR 8'h10
`define UDT_MASK_ADDR 8'h14
`define UDT_ADDR_W 8
// control register fields
`define UDT_CTRL_CAP 0
`define UDT_CTRL_CT 1
`define UDT_CTRL_RUN 2
`define UDT_CTRL_TRANSMIT_CLOCK_SELECT 4
`define UDT_CTRL_RCLK 5
// mode register fields
`define UDT_MODE_DOWN_COUNT_ENABLE 0
// status register fields
`define UDT_ST_OVF 0
`define UDT_ST_EXT 1
`define UDT_ZERO32 32'h0000_0000
`define UDT_ZERO16 16'h0000
`define UDT_ONES16 16'hFFFF
`define UDT_ZERO8 8'h00
`define UDT_ONE8 8'h01
`define UDT_ONES8 8'hFF
`define UDT_PRESCALE 4'hB
`define UDT_ZERO4 4'h0
`define UDT_ONE4 4'h1
`endif

// >>> udt_pin_model.sv
// stand-in for the external count and direction sources
`timescale 1ns/10ps
module udt_pin_model (
    input wire logic clk_in,
    output logic ext_count_pin_out,
    output logic direction_pin_out
);
    initial begin
        ext_count_pin_out = 1'h1;
        direction_pin_out = 1'h1;
    end
    // settle time covers the two-flop synchroniser
    task automatic set_dir(input logic up);
        direction_pin_out <= up;
        repeat (4) @(posedge clk_in);
    endtask
    // slow pulses stretch each level to three clocks
    task automatic pulses(input int n, input logic slow);
        for (int i = 0; i < n; i++) begin
            ext_count_pin_out <= 1'h0;
            repeat (slow ? 3 : 2) @(posedge clk_in);
            ext_count_pin_out <= 1'h1;
            repeat (slow ? 3 : 2) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// >>> udt_pkg.sv
// types shared by the up/down timer files
package udt_pkg;
    typedef enum logic [1:0] {
        UDT_MODE_CAPTURE,
        UDT_MODE_RELOAD,
        UDT_MODE_BAUD
    } udt_mode_t;
endpackage

// >>> udt_sync.sv
// two-flop synchroniser for the external pins
`timescale 1ns/10ps
module udt_sync (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = d_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_out = sync_q;
endmodule

// >>> udt_timer.sv
// up/down auto-reload timer with AHB-Lite register slave
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
`include "udt_map.svh"
module udt_timer (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic ext_count_pin_in,
    input wire logic direction_pin_in,
    output logic irq_out
);
    logic count_pin_s;
    logic dir_pin_s;
    logic count_pin_prev_q;
    logic count_pin_prev_d;

    // R14
    udt_sync u_sync_count (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .d_in(ext_count_pin_in),
        .q_out(count_pin_s)
    );

    // R14
    udt_sync u_sync_dir (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .d_in(direction_pin_in),
        .q_out(dir_pin_s)
    );

    // bus address phase capture
    logic wr_pend_q;
    logic wr_pend_d;
    logic [`UDT_ADDR_W-1:0] wr_addr_q;
    logic [`UDT_ADDR_W-1:0] wr_addr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic addr_phase;

    // software state
    logic capture_reload_select_q;
    logic capture_reload_select_d;
    logic counter_timer_select_q;
    logic counter_timer_select_d;
    logic run_control_q;
    logic run_control_d;
    logic transmit_clock_select_q;
    logic transmit_clock_select_d;
    logic receive_clock_select_q;
    logic receive_clock_select_d;
    logic down_count_enable_q;
    logic down_count_enable_d;
    logic [7:0] count_low_byte_q;
    logic [7:0] count_low_byte_d;
    logic [7:0] count_high_byte_q;
    logic [7:0] count_high_byte_d;
    logic [7:0] reload_low_byte_q;
    logic [7:0] reload_low_byte_d;
    logic [7:0] reload_high_byte_q;
    logic [7:0] reload_high_byte_d;
    logic overflow_flag_q;
    logic overflow_flag_d;
    logic external_flag_q;
    logic external_flag_d;
    logic [1:0] irq_mask_q;
    logic [1:0] irq_mask_d;
    logic [3:0] prescale_q;
    logic [3:0] prescale_d;

    logic tick;
    logic count_up;
    logic wrap_up;
    logic wrap_down;
    logic updown;
    logic ovf_event;
    logic ext_event;
    logic [15:0] count;
    logic [15:0] reload;
    udt_pkg::udt_mode_t mode;

    assign count = {count_high_byte_q, count_low_byte_q};
    assign reload = {reload_high_byte_q, reload_low_byte_q};
    assign addr_phase = hsel_in && hready_in && htrans_in[1];

    // R04
    always_comb begin
        if (receive_clock_select_q || transmit_clock_select_q) begin
            mode = udt_pkg::UDT_MODE_BAUD;
        end else if (capture_reload_select_q) begin
            mode = udt_pkg::UDT_MODE_CAPTURE;
        end else begin
            mode = udt_pkg::UDT_MODE_RELOAD;
        end
    end

    // timer source: divide by 12, counter source: falling edge of pin
    always_comb begin
        count_pin_prev_d = count_pin_s;
        prescale_d = prescale_q;
        if (run_control_q) begin
            if (prescale_q == `UDT_PRESCALE) begin
                prescale_d = `UDT_ZERO4;
            end else begin
                prescale_d = prescale_q + `UDT_ONE4;
            end
        end
        if (counter_timer_select_q) begin
            tick = run_control_q && count_pin_prev_q && !count_pin_s; // R13 R02 R03
        end else begin
            tick = run_control_q && (prescale_q == `UDT_PRESCALE); // R02 R03
        end
    end

    // direction only from the pin when down counting is enabled in reload mode
    always_comb begin
        updown = (mode == udt_pkg::UDT_MODE_RELOAD) && down_count_enable_q; // R06
        count_up = !updown || dir_pin_s; // R05 R06 R07 R09
        wrap_up = tick && count_up && (count == `UDT_ONES16); // R07
        wrap_down = tick && !count_up && (count == reload); // R09
    end

    // counter datapath; capture mode counts up and wraps to zero, baud mode counts up and loads the reload pair
    always_comb begin
        count_low_byte_d = count_low_byte_q;
        count_high_byte_d = count_high_byte_q;
        ovf_event = 1'b0;
        ext_event = 1'b0;
        if (wrap_up) begin
            ovf_event = (mode != udt_pkg::UDT_MODE_BAUD); // R07
            ext_event = updown; // R11
            if (mode == udt_pkg::UDT_MODE_CAPTURE) begin
                count_low_byte_d = `UDT_ZERO8;
                count_high_byte_d = `UDT_ZERO8;
            end else begin
                count_low_byte_d = reload_low_byte_q; // R08
                count_high_byte_d = reload_high_byte_q; // R08
            end
        end else if (wrap_down) begin
            ovf_event = 1'b1; // R10
            ext_event = 1'b1; // R11
            count_low_byte_d = `UDT_ONES8; // R10
            count_high_byte_d = `UDT_ONES8; // R10
        end else if (tick && count_up) begin
            count_low_byte_d = count_low_byte_q + `UDT_ONE8; // R01
            if (count_low_byte_q == `UDT_ONES8) begin
                count_high_byte_d = count_high_byte_q + `UDT_ONE8; // R01
            end
        end else if (tick) begin
            count_low_byte_d = count_low_byte_q - `UDT_ONE8;
            if (count_low_byte_q == `UDT_ZERO8) begin
                count_high_byte_d = count_high_byte_q - `UDT_ONE8;
            end
        end
        // a software write to the count wins over a same-cycle tick
        if (wr_pend_q && wr_addr_q == `UDT_COUNT_ADDR) begin
            count_low_byte_d = hwdata_in[7:0];
            count_high_byte_d = hwdata_in[15:8];
        end
    end

    // register writes and sticky flags
    always_comb begin
        capture_reload_select_d = capture_reload_select_q;
        counter_timer_select_d = counter_timer_select_q;
        run_control_d = run_control_q;
        transmit_clock_select_d = transmit_clock_select_q;
        receive_clock_select_d = receive_clock_select_q;
        down_count_enable_d = down_count_enable_q;
        reload_low_byte_d = reload_low_byte_q;
        reload_high_byte_d = reload_high_byte_q;
        irq_mask_d = irq_mask_q;
        overflow_flag_d = overflow_flag_q;
        external_flag_d = external_flag_q;
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                `UDT_CTRL_ADDR: begin
                    capture_reload_select_d = hwdata_in[`UDT_CTRL_CAP];
                    counter_timer_select_d = hwdata_in[`UDT_CTRL_CT];
                    run_control_d = hwdata_in[`UDT_CTRL_RUN];
                    transmit_clock_select_d = hwdata_in[`UDT_CTRL_TRANSMIT_CLOCK_SELECT];
                    receive_clock_select_d = hwdata_in[`UDT_CTRL_RCLK];
                end
                `UDT_MODE_ADDR: begin
                    down_count_enable_d = hwdata_in[`UDT_MODE_DOWN_COUNT_ENABLE];
                end
                `UDT_RELOAD_ADDR: begin
                    reload_low_byte_d = hwdata_in[7:0];
                    reload_high_byte_d = hwdata_in[15:8];
                end
                `UDT_STATUS_ADDR: begin
                    // write one to clear; only software clears the overflow flag, the external flag also toggles in hardware
                    if (hwdata_in[`UDT_ST_OVF]) begin
                        overflow_flag_d = 1'b0; // R12
                    end
                    if (hwdata_in[`UDT_ST_EXT]) begin
                        external_flag_d = 1'b0;
                    end
                end
                `UDT_MASK_ADDR: begin
                    irq_mask_d = hwdata_in[1:0];
                end
                default: begin
                end
            endcase
        end
        // overflow set and external toggle both win over a same-cycle clear
        if (ovf_event) begin
            overflow_flag_d = 1'b1; // R07 R10
        end
        if (ext_event) begin
            external_flag_d = !external_flag_q; // R11
        end
    end

    // bus address phase and read data
    always_comb begin
        wr_pend_d = addr_phase && hwrite_in;
        wr_addr_d = addr_phase ? haddr_in[`UDT_ADDR_W-1:0] : wr_addr_q;
        rdata_d = rdata_q;
        if (addr_phase && !hwrite_in) begin
            unique case (haddr_in[`UDT_ADDR_W-1:0])
                `UDT_CTRL_ADDR: begin
                    rdata_d = `UDT_ZERO32;
                    rdata_d[`UDT_CTRL_CAP] = capture_reload_select_q;
                    rdata_d[`UDT_CTRL_CT] = counter_timer_select_q;
                    rdata_d[`UDT_CTRL_RUN] = run_control_q;
                    rdata_d[`UDT_CTRL_TRANSMIT_CLOCK_SELECT] = transmit_clock_select_q;
                    rdata_d[`UDT_CTRL_RCLK] = receive_clock_select_q;
                end
                `UDT_MODE_ADDR: begin
                    rdata_d = `UDT_ZERO32;
                    rdata_d[`UDT_MODE_DOWN_COUNT_ENABLE] = down_count_enable_q;
                end
                `UDT_COUNT_ADDR: begin
                    rdata_d = {`UDT_ZERO16, count};
                end
                `UDT_RELOAD_ADDR: begin
                    rdata_d = {`UDT_ZERO16, reload};
                end
                `UDT_STATUS_ADDR: begin
                    rdata_d = `UDT_ZERO32;
                    rdata_d[`UDT_ST_OVF] = overflow_flag_q;
                    rdata_d[`UDT_ST_EXT] = external_flag_q;
                end
                `UDT_MASK_ADDR: begin
                    rdata_d = {30'h0000_0000, irq_mask_q};
                end
                default: begin
                    rdata_d = `UDT_ZERO32;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= `UDT_ZERO8;
            rdata_q <= `UDT_ZERO32;
            capture_reload_select_q <= 1'b0;
            counter_timer_select_q <= 1'b0;
            run_control_q <= 1'b0;
            transmit_clock_select_q <= 1'b0;
            receive_clock_select_q <= 1'b0;
            down_count_enable_q <= 1'b0;
            count_low_byte_q <= `UDT_ZERO8;
            count_high_byte_q <= `UDT_ZERO8;
            reload_low_byte_q <= `UDT_ZERO8;
            reload_high_byte_q <= `UDT_ZERO8;
            overflow_flag_q <= 1'b0;
            external_flag_q <= 1'b0;
            irq_mask_q <= 2'b00;
            prescale_q <= `UDT_ZERO4;
            count_pin_prev_q <= 1'b1;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
            capture_reload_select_q <= capture_reload_select_d;
            counter_timer_select_q <= counter_timer_select_d;
            run_control_q <= run_control_d;
            transmit_clock_select_q <= transmit_clock_select_d;
            receive_clock_select_q <= receive_clock_select_d;
            down_count_enable_q <= down_count_enable_d;
            count_low_byte_q <= count_low_byte_d;
            count_high_byte_q <= count_high_byte_d;
            reload_low_byte_q <= reload_low_byte_d;
            reload_high_byte_q <= reload_high_byte_d;
            overflow_flag_q <= overflow_flag_d;
            external_flag_q <= external_flag_d;
            irq_mask_q <= irq_mask_d;
            prescale_q <= prescale_d;
            count_pin_prev_q <= count_pin_prev_d;
        end
    end

    // external flag is masked out of the interrupt in up/down mode
    assign irq_out = (overflow_flag_q && irq_mask_q[`UDT_ST_OVF])
        || (external_flag_q && irq_mask_q[`UDT_ST_EXT] && !updown); // R11
    assign hrdata_out = rdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
endmodule

// >>> udt_timer_monitor.sv
// port-level assertion checker for the up/down timer
`timescale 1ns/10ps
module udt_timer_monitor (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic rd_q, wr_q, pw_q, cw_q, ov_q, rdok;
    logic [7:0] a_q;
    logic [31:0] ctl_q, mode_q, rl_q, msk_q, cnt_q;
    // a read right behind a write may see the old value, so skip it
    assign rdok = rd_q && !pw_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {rd_q, wr_q, pw_q, cw_q, ov_q, a_q} <= 13'h0000;
            {ctl_q, mode_q, rl_q, msk_q, cnt_q} <= 160'h0;
        end else begin
            rd_q <= hsel_in && hready_in && htrans_in[1] && !hwrite_in;
            wr_q <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
            pw_q <= wr_q;
            a_q <= haddr_in[7:0];
            if (wr_q && a_q == 8'h00) ctl_q <= hwdata_in;
            if (wr_q && a_q == 8'h04) mode_q <= hwdata_in;
            if (wr_q && a_q == 8'h0C) rl_q <= hwdata_in;
            if (wr_q && a_q == 8'h14) msk_q <= hwdata_in;
            if (rd_q && a_q == 8'h08) cnt_q <= hrdata_out;
            cw_q <= (cw_q && !(rd_q && a_q == 8'h08)) || (wr_q && a_q == 8'h08) || ctl_q[2];
            if (rd_q && a_q == 8'h10) ov_q <= hrdata_out[0];
            else if (wr_q && a_q == 8'h10 && hwdata_in[0]) ov_q <= 1'h0;
        end
    end
    AST_UPPER: assert property (rd_q && a_q == 8'h08 |-> hrdata_out[31:16] == 16'h0000)
        else $error("count upper bits not zero");
    AST_HOLD: assert property (rdok && a_q == 8'h08 && !cw_q |-> hrdata_out == cnt_q)
        else $error("count moved while stopped");
    AST_CTRL: assert property (rdok && a_q == 8'h00 |-> hrdata_out == (ctl_q & 32'h0000_0037))
        else $error("control readback wrong");
    AST_DOWN_COUNT_ENABLE: assert property (rdok && a_q == 8'h04 |-> hrdata_out == (mode_q & 32'h0000_0001))
        else $error("mode readback wrong");
    AST_RELOAD: assert property (rdok && a_q == 8'h0C |-> hrdata_out == (rl_q & 32'h0000_FFFF))
        else $error("reload readback wrong");
    AST_STICKY: assert property (rdok && a_q == 8'h10 && ov_q |-> hrdata_out[0])
        else $error("overflow flag cleared by hardware");
    // up/down needs reload mode too: capture and clock selects clear
    AST_IRQ: assert property (rdok && a_q == 8'h10 && !ctl_q[2] |-> irq_out ==
        ((hrdata_out[0] && msk_q[0]) || (hrdata_out[1] && msk_q[1]
        && !(mode_q[0] && ctl_q[5:4] == 2'h0 && !ctl_q[0]))))
        else $error("interrupt level wrong");
    AST_QUIET: assert property (!wr_q && !$past(wr_q) && !ctl_q[2] && !$past(ctl_q[2])
        |-> $stable(irq_out)) else $error("interrupt moved while idle");
    CV_IRQ: cover property ($rose(irq_out));
    CV_EXT: cover property (rd_q && a_q == 8'h10 && hrdata_out[1]);
    CV_TOP: cover property (rd_q && a_q == 8'h08 && hrdata_out[15:0] == 16'hFFFF);
endmodule
bind udt_timer udt_timer_monitor i_mon (.clk_in(clk_in), .resetn_in(resetn_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .irq_out(irq_out));
